/* File: logic/gfpo_defines.svh */
// object dictionary indices, presets and bit positions for the gear, feed and option block
`ifndef GFPO_DEFINES_SVH
`define GFPO_DEFINES_SVH

`define GFPO_IDX_GEAR 16'h60ed
`define GFPO_IDX_FEED 16'h60ee
`define GFPO_IDX_OPT 16'h60f2
`define GFPO_SUB_COUNT 8'h00
`define GFPO_SUB_VAR 8'h00
`define GFPO_SUB_FIRST 8'h01
`define GFPO_NUM_FB 2
`define GFPO_DRV_RESET 32'h0000_0001
`define GFPO_OPT_RESET 16'h0001
`define GFPO_OPT_WMASK 16'h8fff
`define GFPO_CW_NEW_SP 4
`define GFPO_CW_REL 6
`define GFPO_FRAC_BITS 16

`endif

/* File: logic/gfpo_pkg.sv */
// types shared by the gear, feed and positioning option block
package gfpo_pkg;

  typedef enum logic [1:0] {
    rel_prev = 2'h0,
    rel_ramp = 2'h1,
    rel_actual = 2'h2,
    rel_rsvd = 2'h3
  } gfpo_rel_t;

  typedef enum logic [1:0] {
    rls_master = 2'h0,
    rls_on_reach = 2'h1,
    rls_asap = 2'h2,
    rls_rsvd = 2'h3
  } gfpo_rls_t;

  // gray order along idle -> ack -> wait_low
  typedef enum logic [1:0] {
    sp_idle = 2'h0,
    sp_ack = 2'h1,
    sp_wait_low = 2'h3
  } gfpo_sp_t;

  typedef struct packed {
    logic vendor_specific_bit;
    logic [2:0] reserved;
    logic [3:0] interpolation_select;
    logic [1:0] rotary_direction_select;
    gfpo_rls_t setpoint_release_select;
    logic [1:0] change_immediate_select;
    gfpo_rel_t relative_reference_select;
  } gfpo_opt_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] index;
    logic [7:0] sub;
    logic [31:0] wdata;
  } gfpo_od_req_t;

  typedef struct packed {
    logic ack;
    logic err;
    logic [31:0] rdata;
  } gfpo_od_rsp_t;

endpackage

/* File: logic/gfpo_div.sv */
// restoring divider producing an unsigned fixed-point quotient
module gfpo_div #(
  parameter int W = 32,
  parameter int FRAC = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // operands, sampled on start
  input wire logic start,
  input wire logic [W-1:0] num,
  input wire logic [W-1:0] den,
  // result
  output logic busy,
  output logic done,
  output logic div_zero,
  output logic [W-1:0] quot
);

  localparam int N = W + FRAC;
  localparam int CW = $clog2(N + 1);

  logic [N-1:0] acc;
  logic [W:0] rem;
  logic [W-1:0] den_q;
  logic [CW-1:0] cnt;

  wire [W:0] shifted = {rem[W-1:0], acc[N-1]};
  wire fits = shifted >= {1'b0, den_q};
  wire [W:0] diff = shifted - {1'b0, den_q};
  wire [N-1:0] next_acc = {acc[N-2:0], fits};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc <= '0;
      rem <= '0;
      den_q <= '0;
      cnt <= '0;
      busy <= 1'b0;
      done <= 1'b0;
      div_zero <= 1'b0;
      quot <= '0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        if (den == '0) begin
          // a zero denominator saturates instead of hanging the schedule
          done <= 1'b1;
          div_zero <= 1'b1;
          quot <= '1;
        end else begin
          acc <= {num, {FRAC{1'b0}}};
          rem <= '0;
          den_q <= den;
          cnt <= CW'(N);
          busy <= 1'b1;
          div_zero <= 1'b0;
        end
      end else if (busy) begin
        rem <= fits ? diff : shifted;
        acc <= next_acc;
        cnt <= cnt - 1'b1;
        if (cnt == CW'(1)) begin
          busy <= 1'b0;
          done <= 1'b1;
          quot <= (next_acc[N-1:W] != '0) ? '1 : next_acc[W-1:0];
        end
      end
    end
  end

endmodule

/* File: logic/gfpo_top.sv */
// gear ratio, feed constant and positioning option logic of the drive
`include "gfpo_defines.svh"

// What this block does
// - gear ratio equals motor revs over driving revs
// - feed constant equals feed over driving revs
// - entry zero read-only, reports two channels
// - entry one sensorless, entry two internal encoder
// - driving revs entries 32-bit read/write, preset one
// - 16-bit option word read/write, preset 0001h
// - option word field layout fixed as listed
// - relative reference applies only with controlword bit6
// - select 00 adds to previous target
// - select 01 adds to ramp generator output
// - select 10 adds to actual position
// - device clears new-setpoint, then setpoint acknowledge
// - select 01 releases when target reached
// - select 10 releases at earliest moment
module gfpo_top #(
  parameter int NFB = `GFPO_NUM_FB,
  parameter int W = 32,
  parameter int FRAC = `GFPO_FRAC_BITS
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // object dictionary access
  input wire gfpo_pkg::gfpo_od_req_t od_req,
  output gfpo_pkg::gfpo_od_rsp_t od_rsp,
  // numerators from the motor shaft and feed objects
  input wire logic [NFB-1:0][W-1:0] motor_revs,
  input wire logic [NFB-1:0][W-1:0] feed_amount,
  // scaled results with FRAC fraction bits
  output logic [NFB-1:0][W-1:0] gear_ratio,
  output logic [NFB-1:0][W-1:0] feed_const,
  output logic [NFB-1:0] gear_zero,
  output logic [NFB-1:0] feed_zero,
  // profile position move
  input wire logic [15:0] ctrl_word,
  input wire logic signed [W-1:0] target_in,
  input wire logic signed [W-1:0] ramp_pos,
  input wire logic signed [W-1:0] actual_pos,
  input wire logic target_reached,
  output logic signed [W-1:0] abs_target,
  output logic target_load,
  output logic setpoint_ack,
  output logic new_sp_release,
  // option word towards the rest of the drive
  output gfpo_pkg::gfpo_opt_t opt
);

  localparam int IW = (NFB > 1) ? $clog2(NFB) : 1;

  function automatic logic sub_ok(input logic [7:0] s);
    return (s >= `GFPO_SUB_FIRST) && (s <= 8'(NFB));
  endfunction

  // subindex one maps to channel zero, the sensorless feedback
  function automatic logic [IW-1:0] fb_idx(input logic [7:0] s);
    logic [7:0] d;
    d = s - `GFPO_SUB_FIRST;
    return d[IW-1:0];
  endfunction

  // ---------------- object dictionary decode
  wire req = od_req.wr | od_req.rd;
  wire is_gear = od_req.index == `GFPO_IDX_GEAR;
  wire is_feed = od_req.index == `GFPO_IDX_FEED;
  wire is_opt = od_req.index == `GFPO_IDX_OPT;
  wire arr_entry = (is_gear | is_feed) && sub_ok(od_req.sub);
  wire arr_count = (is_gear | is_feed) && (od_req.sub == `GFPO_SUB_COUNT);
  wire opt_hit = is_opt && (od_req.sub == `GFPO_SUB_VAR);
  wire [IW-1:0] wi = fb_idx(od_req.sub);
  wire wr_gear = od_req.wr && is_gear && arr_entry;
  wire wr_feed = od_req.wr && is_feed && arr_entry;
  wire wr_opt = od_req.wr && opt_hit;
  wire rd_valid = arr_count | arr_entry | opt_hit;
  wire wr_valid = arr_entry | opt_hit;

  logic [NFB-1:0][W-1:0] drv_gear;
  logic [NFB-1:0][W-1:0] drv_feed;
  logic [31:0] rd_data;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NFB; i++) begin
        drv_gear[i] <= W'(`GFPO_DRV_RESET);
      end
    end else if (wr_gear) begin
      drv_gear[wi] <= W'(od_req.wdata);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NFB; i++) begin
        drv_feed[i] <= W'(`GFPO_DRV_RESET);
      end
    end else if (wr_feed) begin
      drv_feed[wi] <= W'(od_req.wdata);
    end
  end

  // reserved bits are dropped on write so they always read as zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      opt <= gfpo_pkg::gfpo_opt_t'(`GFPO_OPT_RESET);
    end else if (wr_opt) begin
      opt <= gfpo_pkg::gfpo_opt_t'(od_req.wdata[15:0] & `GFPO_OPT_WMASK);
    end
  end

  always_comb begin
    rd_data = '0;
    if (arr_count) begin
      rd_data = 32'(NFB);
    end else if (is_gear && arr_entry) begin
      rd_data = 32'(drv_gear[wi]);
    end else if (is_feed && arr_entry) begin
      rd_data = 32'(drv_feed[wi]);
    end else if (opt_hit) begin
      rd_data = 32'(opt);
    end
  end

  // a write to the count entry is refused like an unmapped object
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      od_rsp <= '0;
    end else begin
      od_rsp.ack <= req;
      od_rsp.err <= od_req.wr ? !wr_valid : (od_req.rd && !rd_valid);
      od_rsp.rdata <= (od_req.rd && !od_req.wr) ? rd_data : '0;
    end
  end

  // ---------------- ratio computation, one shared divider in round robin
  logic [IW-1:0] slot_ch;
  logic slot_feed;
  logic div_go;
  logic div_wait;
  wire div_busy;
  wire div_done;
  wire div_zero_w;
  wire [W-1:0] div_quot;

  wire [W-1:0] div_num = slot_feed ? feed_amount[slot_ch] : motor_revs[slot_ch];
  wire [W-1:0] div_den = slot_feed ? drv_feed[slot_ch] : drv_gear[slot_ch];

  gfpo_div #(
    .W(W),
    .FRAC(FRAC)
  ) u_div (
    .clk(clk),
    .rst(rst),
    .start(div_go),
    .num(div_num),
    .den(div_den),
    .busy(div_busy),
    .done(div_done),
    .div_zero(div_zero_w),
    .quot(div_quot)
  );

  // results lag a register change by up to one full round of the divider plus one division
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      slot_ch <= '0;
      slot_feed <= 1'b0;
      div_go <= 1'b0;
      div_wait <= 1'b0;
    end else begin
      div_go <= 1'b0;
      if (!div_wait && !div_busy) begin
        div_go <= 1'b1;
        div_wait <= 1'b1;
      end else if (div_done) begin
        div_wait <= 1'b0;
        if (slot_ch == IW'(NFB - 1)) begin
          slot_ch <= '0;
          slot_feed <= !slot_feed;
        end else begin
          slot_ch <= slot_ch + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gear_ratio <= '0;
      feed_const <= '0;
      gear_zero <= '0;
      feed_zero <= '0;
    end else if (div_done) begin
      if (slot_feed) begin
        feed_const[slot_ch] <= div_quot;
        feed_zero[slot_ch] <= div_zero_w;
      end else begin
        gear_ratio[slot_ch] <= div_quot;
        gear_zero[slot_ch] <= div_zero_w;
      end
    end
  end

  // ---------------- new setpoint and target
  wire nsp = ctrl_word[`GFPO_CW_NEW_SP];
  wire rel_move = ctrl_word[`GFPO_CW_REL];
  gfpo_pkg::gfpo_sp_t sp_st;
  gfpo_pkg::gfpo_rls_t rls_mode;
  logic nsp_q;
  logic signed [W-1:0] base;
  logic signed [W-1:0] next_target;

  wire accept = (sp_st == gfpo_pkg::sp_idle) && nsp && !nsp_q;
  wire do_release = (sp_st == gfpo_pkg::sp_ack)
    && ((rls_mode == gfpo_pkg::rls_asap)
    || ((rls_mode == gfpo_pkg::rls_on_reach) && target_reached));

  // abs_target doubles as the previous target; it resets to zero for the first move
  always_comb begin
    base = '0;
    case (opt.relative_reference_select)
      gfpo_pkg::rel_ramp: base = ramp_pos;
      gfpo_pkg::rel_actual: base = actual_pos;
      default: base = abs_target;
    endcase
    next_target = rel_move ? base + target_in : target_in;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      abs_target <= '0;
      target_load <= 1'b0;
    end else begin
      target_load <= accept;
      if (accept) begin
        abs_target <= next_target;
      end
    end
  end

  // release mode is frozen at accept so a later option write cannot strand the handshake
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sp_st <= gfpo_pkg::sp_idle;
      rls_mode <= gfpo_pkg::rls_master;
      setpoint_ack <= 1'b0;
      new_sp_release <= 1'b0;
      nsp_q <= 1'b0;
    end else begin
      nsp_q <= nsp;
      new_sp_release <= 1'b0;
      case (sp_st)
        gfpo_pkg::sp_idle: begin
          if (accept) begin
            setpoint_ack <= 1'b1;
            sp_st <= gfpo_pkg::sp_ack;
            if (opt.setpoint_release_select == gfpo_pkg::rls_rsvd) begin
              rls_mode <= gfpo_pkg::rls_master;
            end else begin
              rls_mode <= opt.setpoint_release_select;
            end
          end
        end
        gfpo_pkg::sp_ack: begin
          if (do_release) begin
            new_sp_release <= 1'b1;
            sp_st <= gfpo_pkg::sp_wait_low;
          end else if ((rls_mode == gfpo_pkg::rls_master) && !nsp) begin
            setpoint_ack <= 1'b0;
            sp_st <= gfpo_pkg::sp_idle;
          end
        end
        gfpo_pkg::sp_wait_low: begin
          if (!nsp) begin
            setpoint_ack <= 1'b0;
            sp_st <= gfpo_pkg::sp_idle;
          end
        end
        default: begin
          sp_st <= gfpo_pkg::sp_idle;
        end
      endcase
    end
  end

  // ---------------- checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_accept_rel;
    accept && rel_move;
  endsequence

  sequence s_released;
    new_sp_release ##1 !nsp;
  endsequence

  property p_count_read;
    (od_req.rd && !od_req.wr && arr_count)
      |=> (od_rsp.ack && !od_rsp.err && (od_rsp.rdata == 32'(NFB)));
  endproperty
  a_count_read: assert property (p_count_read) else $error("count entry read wrong");

  property p_count_ro;
    (od_req.wr && arr_count) |=> (od_rsp.ack && od_rsp.err);
  endproperty
  a_count_ro: assert property (p_count_ro) else $error("count entry write not refused");

  property p_drv_write;
    wr_gear |=> (drv_gear[$past(wi)] == W'($past(od_req.wdata)));
  endproperty
  a_drv_write: assert property (p_drv_write) else $error("driving revs not stored");

  property p_opt_write;
    wr_opt |=> (16'(opt) == ($past(od_req.wdata[15:0]) & `GFPO_OPT_WMASK));
  endproperty
  a_opt_write: assert property (p_opt_write) else $error("option word not stored");

  property p_opt_rsvd;
    opt.reserved == '0;
  endproperty
  a_opt_rsvd: assert property (p_opt_rsvd) else $error("reserved option bits set");

  property p_abs_move;
    (accept && !rel_move) |=> (target_load && (abs_target == $past(target_in)));
  endproperty
  a_abs_move: assert property (p_abs_move) else $error("absolute move offset");

  property p_rel_prev;
    s_accept_rel ##0 (opt.relative_reference_select == gfpo_pkg::rel_prev)
      |=> (abs_target == $past(abs_target) + $past(target_in));
  endproperty
  a_rel_prev: assert property (p_rel_prev) else $error("relative to previous wrong");

  property p_rel_ramp;
    s_accept_rel ##0 (opt.relative_reference_select == gfpo_pkg::rel_ramp)
      |=> (abs_target == $past(ramp_pos) + $past(target_in));
  endproperty
  a_rel_ramp: assert property (p_rel_ramp) else $error("relative to ramp wrong");

  property p_rel_actual;
    s_accept_rel ##0 (opt.relative_reference_select == gfpo_pkg::rel_actual)
      |=> (abs_target == $past(actual_pos) + $past(target_in));
  endproperty
  a_rel_actual: assert property (p_rel_actual) else $error("relative to actual wrong");

  property p_rel_rsvd;
    s_accept_rel ##0 (opt.relative_reference_select == gfpo_pkg::rel_rsvd)
      |=> (abs_target == $past(abs_target) + $past(target_in));
  endproperty
  a_rel_rsvd: assert property (p_rel_rsvd) else $error("reserved select not as 00");

  property p_ack_held;
    new_sp_release |-> setpoint_ack;
  endproperty
  a_ack_held: assert property (p_ack_held) else $error("ack dropped before release");

  property p_ack_clear;
    s_released |=> !setpoint_ack;
  endproperty
  a_ack_clear: assert property (p_ack_clear) else $error("ack not cleared after release");

  property p_master_clear;
    ((sp_st == gfpo_pkg::sp_ack) && (rls_mode == gfpo_pkg::rls_master))
      |=> (!new_sp_release && (setpoint_ack == $past(nsp)));
  endproperty
  a_master_clear: assert property (p_master_clear) else $error("master mode misbehaves");

  property p_release_reach;
    ((sp_st == gfpo_pkg::sp_ack) && (rls_mode == gfpo_pkg::rls_on_reach))
      |=> (new_sp_release == $past(target_reached));
  endproperty
  a_release_reach: assert property (p_release_reach) else $error("reach release wrong");

  property p_release_asap;
    (accept && (opt.setpoint_release_select == gfpo_pkg::rls_asap))
      |-> ##1 !new_sp_release ##1 new_sp_release ##1 !new_sp_release;
  endproperty
  a_release_asap: assert property (p_release_asap) else $error("asap release late");

endmodule

/* File: dv/gfpo_master.sv */
// fieldbus master model that owns the controlword during setpoint handshakes
module gfpo_master (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // commands from the bench
  input wire logic go,
  input wire logic rel,
  input wire logic self_clear,
  // drive status
  input wire logic setpoint_ack,
  input wire logic new_sp_release,
  // controlword towards the drive
  output logic [15:0] ctrl_word
);
  timeunit 1ns;
  timeprecision 1ps;
  // only bits 4 and 6 are modelled; the rest of the word stays low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_word <= 16'h0000;
    end else if (go) begin
      ctrl_word[4] <= 1'b1;
      ctrl_word[6] <= rel;
    end else if (new_sp_release) begin
      // the drive's release request is applied as if it wrote the bit itself
      ctrl_word[4] <= 1'b0;
    end else if (self_clear && setpoint_ack) begin
      ctrl_word[4] <= 1'b0;
    end
  end
endmodule

/* File: dv/tb_gfpo_top.sv */
// self-checking bench for the gear, feed and positioning option block
module tb_gfpo_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic wr;
    logic [15:0] idx;
    logic [7:0] sub;
    logic [31:0] wd;
    logic er;
    logic [31:0] rd;
  } gfpo_row_t;
  logic clk, rst, target_reached, target_load, setpoint_ack, new_sp_release, go, rel, self_clear;
  gfpo_pkg::gfpo_od_req_t od_req;
  gfpo_pkg::gfpo_od_rsp_t od_rsp;
  gfpo_pkg::gfpo_opt_t opt;
  logic [1:0][31:0] motor_revs, feed_amount, gear_ratio, feed_const;
  logic [1:0] gear_zero, feed_zero;
  logic [15:0] ctrl_word;
  logic signed [31:0] target_in, ramp_pos, actual_pos, abs_target, prev_abs;
  int err_total, samples_checked, cycles, pulses;
  gfpo_row_t rows[15] = '{
    '{1'b0, 16'h60ed, 8'h00, 32'h0, 1'b0, 32'h0000_0002},
    '{1'b0, 16'h60ee, 8'h00, 32'h0, 1'b0, 32'h0000_0002},
    '{1'b0, 16'h60ed, 8'h01, 32'h0, 1'b0, 32'h0000_0001},
    '{1'b0, 16'h60ed, 8'h02, 32'h0, 1'b0, 32'h0000_0001},
    '{1'b0, 16'h60ee, 8'h02, 32'h0, 1'b0, 32'h0000_0001},
    '{1'b0, 16'h60f2, 8'h00, 32'h0, 1'b0, 32'h0000_0001},
    '{1'b1, 16'h60ed, 8'h00, 32'h0000_0005, 1'b1, 32'h0},
    '{1'b0, 16'h60ed, 8'h00, 32'h0, 1'b0, 32'h0000_0002},
    '{1'b0, 16'h60ed, 8'h03, 32'h0, 1'b1, 32'h0},
    '{1'b0, 16'h60f2, 8'h01, 32'h0, 1'b1, 32'h0},
    '{1'b0, 16'h6064, 8'h00, 32'h0, 1'b1, 32'h0},
    '{1'b1, 16'h60ed, 8'h02, 32'hdead_beef, 1'b0, 32'h0},
    '{1'b0, 16'h60ed, 8'h02, 32'h0, 1'b0, 32'hdead_beef},
    '{1'b1, 16'h60f2, 8'h00, 32'hffff_f0a5, 1'b0, 32'h0},
    '{1'b0, 16'h60f2, 8'h00, 32'h0, 1'b0, 32'h0000_80a5}
  };

  gfpo_top dut_u (.clk(clk), .rst(rst), .od_req(od_req), .od_rsp(od_rsp),
    .motor_revs(motor_revs), .feed_amount(feed_amount), .gear_ratio(gear_ratio),
    .feed_const(feed_const), .gear_zero(gear_zero), .feed_zero(feed_zero),
    .ctrl_word(ctrl_word), .target_in(target_in), .ramp_pos(ramp_pos),
    .actual_pos(actual_pos), .target_reached(target_reached), .abs_target(abs_target),
    .target_load(target_load), .setpoint_ack(setpoint_ack),
    .new_sp_release(new_sp_release), .opt(opt));
  gfpo_master master_u (.clk(clk), .rst(rst), .go(go), .rel(rel), .self_clear(self_clear),
    .setpoint_ack(setpoint_ack), .new_sp_release(new_sp_release), .ctrl_word(ctrl_word));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (new_sp_release === 1'b1) pulses++;
    // generous ceiling: the whole sequence needs several hundred cycles
    if (cycles == 20000) begin
      err_total++;
      close_out();
    end
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  task automatic od_acc(input gfpo_row_t r);
    od_req.wr = r.wr;
    od_req.rd = !r.wr;
    od_req.index = r.idx;
    od_req.sub = r.sub;
    od_req.wdata = r.wd;
    tick();
    chk("od ack", od_rsp.ack, 1'b1);
    chk("od err", od_rsp.err, r.er);
    chk("od rdata", od_rsp.rdata, r.rd);
    // an idle edge before the next request keeps the strobes at one change per time step
    od_req.wr = 1'b0;
    od_req.rd = 1'b0;
    tick();
  endtask

  task automatic move(input logic r, input logic [1:0] k, input logic signed [31:0] t);
    logic signed [31:0] exp;
    int p0, n;
    od_acc('{1'b1, 16'h60f2, 8'h00, {26'h0, k, 2'h0, k}, 1'b0, 32'h0});
    chk("rel select", opt.relative_reference_select, k);
    chk("release select", opt.setpoint_release_select, k);
    exp = !r ? t : (k == 2'h1) ? ramp_pos + t : (k == 2'h2) ? actual_pos + t : prev_abs + t;
    target_in = t;
    p0 = pulses;
    rel = r;
    self_clear = (k == 2'h0 || k == 2'h3);
    go = 1'b1;
    tick();
    go = 1'b0;
    n = 0;
    while (target_load !== 1'b1 && n < 20) begin
      tick();
      n++;
    end
    chk("target load", target_load, 1'b1);
    chk("abs target", abs_target, exp);
    chk("sp ack set", setpoint_ack, 1'b1);
    prev_abs = exp;
    if (k == 2'h2) begin
      tick();
      chk("asap release", new_sp_release, 1'b1);
    end
    if (k == 2'h1) begin
      repeat (4) tick();
      chk("early release", pulses - p0, 0);
      target_reached = 1'b1;
    end
    n = 0;
    while (setpoint_ack !== 1'b0 && n < 40) begin
      tick();
      n++;
    end
    target_reached = 1'b0;
    chk("sp ack cleared", setpoint_ack, 1'b0);
    chk("release pulses", pulses - p0, (k == 2'h1 || k == 2'h2));
    chk("new sp bit", ctrl_word[4], 1'b0);
    $display("move with mode %0d done", k);
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    rst = 1'b1;
    od_req = '0;
    motor_revs = {32'h0000_0003, 32'h0000_0008};
    feed_amount = {32'h0000_0006, 32'h0000_0001};
    target_in = 32'sh0;
    ramp_pos = 32'sh0000_03e8;
    actual_pos = -32'sh0000_01f4;
    target_reached = 1'b0;
    go = 1'b0;
    rel = 1'b0;
    self_clear = 1'b0;
    prev_abs = 32'sh0;
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    chk("opt preset", opt, 16'h0001);
    chk("abs preset", abs_target, 32'h0);
    chk("ack preset", setpoint_ack, 1'b0);
    tick();
    foreach (rows[i]) od_acc(rows[i]);
    $display("register table done");
    // channel zero is sub 1, channel one is sub 2
    od_acc('{1'b1, 16'h60ed, 8'h01, 32'h0000_0004, 1'b0, 32'h0});
    od_acc('{1'b1, 16'h60ed, 8'h02, 32'h0, 1'b0, 32'h0});
    od_acc('{1'b1, 16'h60ee, 8'h02, 32'h0000_0002, 1'b0, 32'h0});
    repeat (500) tick();
    chk("gear ch0", gear_ratio[0], 32'h0002_0000);
    chk("gear ch1", gear_ratio[1], 32'hffff_ffff);
    chk("gear zero", gear_zero, 2'h2);
    chk("feed ch0", feed_const[0], 32'h0001_0000);
    chk("feed ch1", feed_const[1], 32'h0003_0000);
    chk("feed zero", feed_zero, 2'h0);
    $display("ratio test done");
    move(1'b1, 2'h0, 32'sh64);
    move(1'b1, 2'h1, 32'sh32);
    move(1'b1, 2'h2, 32'sh14);
    move(1'b1, 2'h3, 32'sh7);
    move(1'b1, 2'h0, 32'sh3);
    move(1'b0, 2'h1, 32'sh2a);
    // mid-run reset must bring every register back to its preset
    rst = 1'b1;
    repeat (2) tick();
    rst = 1'b0;
    chk("opt reset", opt, 16'h0001);
    chk("abs reset", abs_target, 32'h0);
    chk("gear reset", gear_ratio[0], 32'h0);
    chk("ack reset", setpoint_ack, 1'b0);
    tick();
    od_acc('{1'b0, 16'h60ed, 8'h01, 32'h0, 1'b0, 32'h0000_0001});
    od_acc('{1'b0, 16'h60ee, 8'h00, 32'h0, 1'b0, 32'h0000_0002});
    // with no previous target a relative move counts from zero
    prev_abs = 32'sh0;
    move(1'b1, 2'h0, 32'sh5);
    $display("mid-run reset done");
    close_out();
  end
endmodule
